// >>> clk_cfg.sv
// Purpose: PLL setup registers, system clock select, panel clock divider
// Assumes: Avalon-MM slave, PLL modelled as a settling timer
// Notes: Panel clock is produced as a registered output of clk, 50/50 for even ratios only
`timescale 1ns/100ps
module clk_cfg #(
  parameter int SETTLE_CYCLES = clk_cfg_pkg::SETTLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [clk_cfg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic sys_clk_sel_pll,
  output logic [6:0] pll_mult,
  output logic pll_active,
  output logic pll_locked,
  output logic panel_clk,
  output logic mem_access_ok,
  output logic irq
);
  import clk_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus: one wait cycle per access, answer in the second cycle
  logic ack_reg;
  logic req;
  logic wr_en;
  logic rd_en;
  assign req = avs_read | avs_write;
  // Write lands only at the edge where the master sees waitrequest low
  assign wr_en = avs_write & ack_reg & avs_byteenable[0];
  assign rd_en = avs_read & ~ack_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & ~ack_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] setup_a_reg;
  logic [7:0] setup_b_reg;
  logic [7:0] setup_c_reg;
  logic [7:0] setup_d_reg;
  logic [7:0] mult_reg;
  logic [7:0] src_div_reg;
  logic [5:0] prediv_reg;
  logic sleep_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_stat_reg;
  logic [7:0] wbyte;
  assign wbyte = avs_writedata[7:0];

  // Setup values are software's duty; the block stores them as written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_a_reg <= RST_REG;
      setup_b_reg <= RST_REG;
      setup_c_reg <= RST_REG;
      setup_d_reg <= RST_REG;
    end else if (wr_en) begin
      if (avs_address == OFF_SETUP_A) setup_a_reg <= wbyte;
      if (avs_address == OFF_SETUP_B) setup_b_reg <= wbyte;
      if (avs_address == OFF_SETUP_C) setup_c_reg <= wbyte;
      if (avs_address == OFF_SETUP_D) setup_d_reg <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_reg <= RST_REG;
      src_div_reg <= RST_REG;
      prediv_reg <= RST_PREDIV[5:0];
      sleep_reg <= 1'b0;
      irq_mask_reg <= 2'b00;
    end else if (wr_en) begin
      // Dummy slot is decoded but stores nothing
      if (avs_address == OFF_MULT) mult_reg <= {1'b0, wbyte[6:0]};
      if (avs_address == OFF_SRC_DIV) src_div_reg <= {wbyte[7:3], 2'b00,
                                                      wbyte[SRC_BIT]};
      if (avs_address == OFF_PREDIV) prediv_reg <= wbyte[5:0];
      if (avs_address == OFF_SLEEP) sleep_reg <= wbyte[SLEEP_BIT];
      if (avs_address == OFF_IRQ_MASK) irq_mask_reg <= wbyte[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL settle model
  pll_state_t pll_state_reg;
  logic [31:0] settle_cnt_reg;
  logic lock_rise;
  logic lock_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_state_reg <= PLL_OFF;
      settle_cnt_reg <= 32'h00000000;
    end else if (sleep_reg) begin
      pll_state_reg <= PLL_OFF;
      settle_cnt_reg <= 32'h00000000;
    end else begin
      unique case (pll_state_reg)
        PLL_OFF: begin
          pll_state_reg <= PLL_SETTLE;
          settle_cnt_reg <= 32'h00000000;
        end
        PLL_SETTLE: begin
          if (settle_cnt_reg == 32'(SETTLE_CYCLES - 1)) begin
            pll_state_reg <= PLL_LOCKED;
          end
          settle_cnt_reg <= settle_cnt_reg + 32'h00000001;
        end
        PLL_LOCKED: begin
          pll_state_reg <= PLL_LOCKED;
        end
        default: begin
          pll_state_reg <= PLL_OFF;
        end
      endcase
    end
  end

  logic locked_now;
  logic locked_d_reg;
  assign locked_now = (pll_state_reg == PLL_LOCKED);
  assign lock_rise = locked_now & ~locked_d_reg;
  assign lock_fall = ~locked_now & locked_d_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_d_reg <= 1'b0;
      pll_locked <= 1'b0;
      mem_access_ok <= 1'b0;
      pll_active <= 1'b0;
      pll_mult <= 7'h00;
    end else begin
      locked_d_reg <= locked_now;
      pll_locked <= locked_now;
      // Effective source, so a pending switch cannot open memory early
      mem_access_ok <= locked_now | ~sys_clk_sel_pll;
      pll_active <= ~sleep_reg;
      pll_mult <= mult_reg[MULT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source switch only on a panel clock period boundary to avoid runts
  logic [4:0] div_cnt_reg;
  logic [4:0] div_live_reg;
  logic [5:0] ratio;
  logic [5:0] half_pos;
  logic [5:0] cnt_x2;
  assign ratio = {1'b0, div_live_reg} + 6'h01;
  assign half_pos = ratio;
  assign cnt_x2 = {div_cnt_reg, 1'b0};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 5'h00;
      div_live_reg <= 5'h01;
      sys_clk_sel_pll <= 1'b0;
    end else if (div_cnt_reg >= div_live_reg) begin
      div_cnt_reg <= 5'h00;
      // Reserved zero keeps the previous ratio
      if (src_div_reg[7:3] != 5'h00) begin
        div_live_reg <= src_div_reg[7:3];
      end
      sys_clk_sel_pll <= src_div_reg[SRC_BIT];
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  // Odd ratios: high for the first half, rounded up so high is one clk
  // longer than low; a flop output cannot split a cycle, so odd ratios differ
  // by one clk at most
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      panel_clk <= 1'b0;
    end else begin
      panel_clk <= (cnt_x2 < half_pos);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over write-one-to-clear
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set = {lock_fall, lock_rise};
  assign irq_clr = (wr_en && avs_address == OFF_IRQ_STAT) ? wbyte[1:0] :
                   2'b00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    unique case (avs_address)
      OFF_SETUP_A: rmux = setup_a_reg;
      OFF_SETUP_B: rmux = setup_b_reg;
      OFF_SETUP_C: rmux = setup_c_reg;
      OFF_SETUP_D: rmux = setup_d_reg;
      OFF_MULT: rmux = mult_reg;
      OFF_DUMMY: rmux = 8'h00;
      OFF_SRC_DIV: rmux = src_div_reg;
      OFF_PREDIV: rmux = {locked_now, 1'b0, prediv_reg};
      OFF_SLEEP: rmux = {6'h00, sleep_reg, 1'b0};
      OFF_IRQ_STAT: rmux = {6'h00, irq_stat_reg};
      OFF_IRQ_MASK: rmux = {6'h00, irq_mask_reg};
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_en) begin
      avs_readdata <= {24'h000000, rmux};
    end
  end
endmodule : clk_cfg

// >>> clk_cfg_pkg.sv
// Purpose: Constants for the clock configuration block
// Assumes: 25 MHz clk, Avalon-MM register slave
// Notes: Registers sit at their printed byte offsets
package clk_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SETUP_A = 8'h06;
  localparam logic [7:0] OFF_SETUP_B = 8'h08;
  localparam logic [7:0] OFF_SETUP_C = 8'h0A;
  localparam logic [7:0] OFF_SETUP_D = 8'h0C;
  localparam logic [7:0] OFF_MULT = 8'h0E;
  localparam logic [7:0] OFF_DUMMY = 8'h10;
  localparam logic [7:0] OFF_SRC_DIV = 8'h12;
  localparam logic [7:0] OFF_PREDIV = 8'h04;
  localparam logic [7:0] OFF_SLEEP = 8'h56;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h70;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h74;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_PREDIV = 8'h00;
  localparam logic [7:0] SETUP_A_VAL = 8'hF8;
  localparam logic [7:0] SETUP_B_VAL = 8'h80;
  localparam logic [7:0] SETUP_C_VAL = 8'h28;
  localparam logic [7:0] SETUP_D_VAL = 8'h00;
  localparam int SRC_BIT = 0;
  localparam int DIV_LSB = 3;
  localparam int MULT_W = 7;
  localparam int SLEEP_BIT = 1;
  localparam int LOCK_BIT = 7;
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_UNLOCK = 1;
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_MS = 10;
  localparam int SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
  typedef enum logic [1:0] {
    PLL_OFF = 2'b00,
    PLL_SETTLE = 2'b01,
    PLL_LOCKED = 2'b11
  } pll_state_t;
endpackage : clk_cfg_pkg

// >>> clk_cfg_chk.sv
// Purpose: Port checker for clk_cfg
// Assumes: One clock, resetn active low
// Notes: Bound at the foot of this file
`timescale 1ns/100ps
module clk_cfg_chk #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [clk_cfg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sys_clk_sel_pll,
  input wire logic [6:0] pll_mult,
  input wire logic pll_active,
  input wire logic pll_locked,
  input wire logic panel_clk,
  input wire logic mem_access_ok
);
  import clk_cfg_pkg::*;
  int act_cnt;
  int hi_cnt;
  int lo_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) act_cnt <= 0;
    else act_cnt <= pll_active ? act_cnt + 1 : 0;
  end
  // Run lengths, so a stretched phase shows up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi_cnt <= 0;
    else hi_cnt <= panel_clk ? hi_cnt + 1 : 0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lo_cnt <= 0;
    else lo_cnt <= panel_clk ? 0 : lo_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  a_rd_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("readdata upper bits set");
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_cause: assert property (
    $fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_mult_write: assert property (
    $changed(pll_mult) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("multiplier changed without write");
  a_sleep_off: assert property (
    !pll_active && $past(!pll_active) |-> !pll_locked)
    else $error("lock while pll inactive");
  a_lock_settle: assert property (
    $rose(pll_locked) |-> act_cnt >= SETTLE_CYCLES - 2)
    else $error("lock before settling time");
  a_mem_block: assert property (
    sys_clk_sel_pll && !pll_locked && $past(sys_clk_sel_pll && !pll_locked)
    |-> !mem_access_ok)
    else $error("memory access allowed while unlocked");
  a_panel_run: assert property (hi_cnt <= 16 && lo_cnt <= 16)
    else $error("panel clock phase too long");
endmodule : clk_cfg_chk

bind clk_cfg clk_cfg_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .clk(clk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sys_clk_sel_pll(sys_clk_sel_pll),
  .pll_mult(pll_mult), .pll_active(pll_active), .pll_locked(pll_locked),
  .panel_clk(panel_clk), .mem_access_ok(mem_access_ok));

// >>> tb.sv
// Purpose: Self-checking bench for clk_cfg
// Assumes: 25 MHz clk, settling cut to 20 cycles
// Notes: Random divider and data from a fixed seed
`timescale 1ns/100ps
module tb;
  import clk_cfg_pkg::*;
  localparam int SC = 20;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sys_clk_sel_pll, pll_active, pll_locked;
  logic panel_clk, mem_access_ok, irq;
  logic [6:0] pll_mult;
  logic [7:0] q, m;
  logic [7:0] offs [8] = '{OFF_SETUP_A, OFF_SETUP_B, OFF_SETUP_C,
    OFF_SETUP_D, OFF_MULT, OFF_DUMMY, OFF_SRC_DIV, 8'h20};
  logic [7:0] vals [4] = '{SETUP_A_VAL, SETUP_B_VAL, SETUP_C_VAL,
    SETUP_D_VAL};
  int miscompares = 0;
  int n_tests = 0;
  int h, l, k;
  clk_cfg #(.SETTLE_CYCLES(SC)) DUT (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sys_clk_sel_pll(sys_clk_sel_pll),
    .pll_mult(pll_mult), .pll_active(pll_active), .pll_locked(pll_locked),
    .panel_clk(panel_clk), .mem_access_ok(mem_access_ok), .irq(irq));
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Each access opens with an edge so a strobe never toggles twice a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Changes land at period end, so skip two long periods first
  task automatic pmeas(input logic [4:0] n, input int r);
    acc(1'b1, OFF_SRC_DIV, {n, 3'b000});
    cyc(70);
    while (panel_clk !== 1'b0) @(posedge clk);
    while (panel_clk !== 1'b1) @(posedge clk);
    for (h = 0; panel_clk === 1'b1; h++) @(posedge clk);
    for (l = 0; panel_clk === 1'b0; l++) @(posedge clk);
    chk("panel period", 32'(r), 32'(h + l));
    chk("panel duty", 32'h1, 32'(h >= l && h - l <= 1));
  endtask : pmeas
  task automatic conclude();
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(32'hD25A));
    cyc(2);
    resetn <= 1'b1;
    cyc(3);
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, offs[i], 8'h00);
      chk("reset value", 32'h0, 32'(q));
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, offs[i], vals[i]);
      acc(1'b0, offs[i], 8'h00);
      chk("setup readback", 32'(vals[i]), 32'(q));
    end
    avs_byteenable <= 4'hE;
    acc(1'b1, OFF_SETUP_A, 8'h55);
    avs_byteenable <= 4'hF;
    acc(1'b0, OFF_SETUP_A, 8'h00);
    chk("masked write", 32'(SETUP_A_VAL), 32'(q));
    m = 8'($urandom());
    acc(1'b1, OFF_MULT, m);
    acc(1'b0, OFF_MULT, 8'h00);
    chk("mult readback", 32'(m[6:0]), 32'(q));
    chk("mult port", 32'(m[6:0]), 32'(pll_mult));
    for (int i = 5; i < 8; i += 2) begin
      acc(1'b1, offs[i], 8'($urandom()));
      acc(1'b0, offs[i], 8'h00);
      chk("no effect", 32'h0, 32'(q));
    end
    acc(1'b1, OFF_SLEEP, 8'h02);
    cyc(3);
    chk("pll active", 32'h0, 32'(pll_active));
    chk("lock in sleep", 32'h0, 32'(pll_locked));
    acc(1'b1, OFF_IRQ_STAT, 8'h03);
    acc(1'b1, OFF_PREDIV, 8'h0B);
    acc(1'b1, OFF_SRC_DIV, 8'h09);
    cyc(8);
    chk("source pll", 32'h1, 32'(sys_clk_sel_pll));
    chk("mem blocked", 32'h0, 32'(mem_access_ok));
    acc(1'b0, OFF_PREDIV, 8'h00);
    chk("lock bit low", 32'h0, 32'(q[LOCK_BIT]));
    chk("prediv readback", 32'h0B, 32'(q[5:0]));
    acc(1'b1, OFF_SLEEP, 8'h00);
    for (k = 0; pll_locked !== 1'b1 && k < 100; k++) @(posedge clk);
    chk("settle time", 32'h1, 32'(k >= SC - 4 && k <= SC + 4));
    cyc(2);
    chk("mem allowed", 32'h1, 32'(mem_access_ok));
    acc(1'b0, OFF_PREDIV, 8'h00);
    chk("lock bit high", 32'h1, 32'(q[LOCK_BIT]));
    acc(1'b0, OFF_IRQ_STAT, 8'h00);
    chk("lock event", 32'h1, 32'(q[IRQ_LOCK]));
    acc(1'b1, OFF_IRQ_MASK, 8'h00);
    cyc(2);
    m[0] = irq;
    acc(1'b1, OFF_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq mask", 32'h0, 32'(m[0]));
    chk("irq unmasked", 32'h1, 32'(irq));
    acc(1'b1, OFF_IRQ_STAT, 8'h01);
    cyc(2);
    chk("irq cleared", 32'h0, 32'(irq));
    pmeas(5'd1, 2);
    pmeas(5'd31, 32);
    repeat (3) begin
      k = $urandom_range(31, 1);
      pmeas(5'(k), k + 1);
    end
    pmeas(5'd0, k + 1);
    chk("source ext", 32'h0, 32'(sys_clk_sel_pll));
    conclude();
  end
endmodule : tb
